// *** verilog/vwi_inserter.v ***
// VBI and wide-screen signalling inserter for the TV output path.
// Assumes line and field timing from the TV timing generator on clk_sys.
`include "vwi_regs.vh"

module vwi_inserter
#(
    parameter CC_BIT_CYCLES  = `VWI_CC_BIT_CYCLES,
    parameter WSS_BIT_CYCLES = `VWI_WSS_BIT_CYCLES
)
(
    // Clock and reset
    input  wire        clk_sys,
    input  wire        rst_b,
    // Register port
    input  wire [7:0]  regAddr,
    input  wire        regWrEn,
    input  wire [7:0]  regWrData,
    input  wire        regRdEn,
    output reg  [7:0]  regRdData,
    // TV timing
    input  wire        lineStart,
    input  wire [9:0]  lineNum,
    input  wire        fieldTwo,
    input  wire        vsync,
    input  wire [1:0]  tvStandard,
    input  wire [1:0]  vbiStandard,
    // Encoder side
    output reg         vbiActive,
    output reg         vbiBit,
    output reg         vbiSubcarrier
);

    // Odd parity in bit 7 of a caption character
    function [7:0] ccChar;
        input [6:0] c;
        begin
            ccChar = {~^c, c};
        end
    endfunction

    reg  rstMeta_reg;
    reg  rstSync_reg;
    reg  [7:0] data0_reg, data1_reg, data2_reg, data3_reg;
    reg  [3:0] ctrl_reg;
    reg  [3:0] fieldCnt_reg;
    reg  [6:0] gapCnt_reg;
    reg        manField_reg;
    reg        manBusy_reg;
    reg        modSel_reg;
    wire       txBitW, txBusyW, txDoneW;

    // Two-stage release of the asynchronous reset
    always @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rstMeta_reg <= 1'b0;
            rstSync_reg <= 1'b0;
        end
        else
        begin
            rstMeta_reg <= 1'b1;
            rstSync_reg <= rstMeta_reg;
        end
    end

    // Packet characters built from the data registers
    wire [6:0] aspS   = {1'b1, data0_reg[5:0]};
    wire [6:0] aspE   = {1'b1, data1_reg[3:0], data0_reg[7:6]};
    wire [6:0] aspQ   = {6'h20, data1_reg[4]};
    wire [6:0] cgA    = {2'h2, data2_reg[1:0], data1_reg[7:5]};
    wire [6:0] cgB    = {1'b0, data2_reg[7:2]};
    wire [6:0] aspSum = 7'h0 - (`VWI_CC_START + `VWI_CC_ASPECT + aspS + aspE
                              + aspQ + `VWI_CC_END);
    wire [6:0] cgSum  = 7'h0 - (`VWI_CC_START + `VWI_CC_CGMS + cgA + cgB
                              + `VWI_CC_END);

    // Pair for the current field-2 slot, lsb first
    reg [15:0] autoPair;
    always @*
    begin
        case (fieldCnt_reg[3:1])
            3'h0: autoPair = {ccChar(`VWI_CC_ASPECT), ccChar(`VWI_CC_START)};
            3'h1: autoPair = {ccChar(aspE), ccChar(aspS)};
            3'h2: autoPair = {ccChar(7'h0), ccChar(aspQ)};
            3'h3: autoPair = {ccChar(aspSum), ccChar(`VWI_CC_END)};
            3'h4: autoPair = {ccChar(`VWI_CC_CGMS), ccChar(`VWI_CC_START)};
            3'h5: autoPair = {ccChar(cgB), ccChar(cgA)};
            3'h6: autoPair = {ccChar(cgSum), ccChar(`VWI_CC_END)};
            default: autoPair = {ccChar(cgSum), ccChar(`VWI_CC_END)};
        endcase
    end

    // Line selection per standard and output system
    reg        lineHit;
    reg        useCc;
    reg [5:0]  lineBits;
    reg        lineBip;
    reg        lineMod;
    wire       is625 = (tvStandard == `VWI_TV_PAL625);
    wire       f1 = !fieldTwo;
    always @*
    begin
        lineHit  = 1'b0;
        useCc    = 1'b0;
        lineBits = `VWI_BITS_WSS625;
        lineBip  = 1'b1;
        lineMod  = 1'b0;
        case (vbiStandard)
            `VWI_STD_ETSI:
                lineHit = is625 && lineNum == `VWI_LINE_WSS625;
            `VWI_STD_ITU:
            begin
                if (is625)
                    lineHit = lineNum == `VWI_LINE_WSS625;
                else
                begin
                    lineHit  = lineNum == (f1 ? `VWI_LINE_ITU525_F1
                                              : `VWI_LINE_ITU525_F2);
                    lineBits = `VWI_BITS_ITU525;
                    lineBip  = 1'b0;
                    lineMod  = 1'b1;
                end
            end
            `VWI_STD_IEC:
            begin
                lineHit  = tvStandard == `VWI_TV_NTSC &&
                           lineNum == (f1 ? `VWI_LINE_IEC_F1
                                          : `VWI_LINE_IEC_F2);
                lineBits = `VWI_BITS_IEC;
                lineBip  = 1'b0;
            end
            `VWI_STD_CC:
            begin
                useCc    = 1'b1;
                lineBits = `VWI_BITS_CC;
                lineBip  = 1'b0;
                if (tvStandard == `VWI_TV_NTSC)
                    lineHit = lineNum == (f1 ? `VWI_LINE_CC525_F1
                                             : `VWI_LINE_CC525_F2);
                else if (is625)
                    lineHit = lineNum == (f1 ? `VWI_LINE_CC625_F1
                                             : `VWI_LINE_CC625_F2);
            end
            default: lineHit = 1'b0;
        endcase
    end

    // What this line sends, if anything
    wire        autoMode = ctrl_reg[`VWI_CTRL_AUTO];
    wire        inGap    = gapCnt_reg != 7'h0;
    wire        manArm   = f1 ? ctrl_reg[`VWI_CTRL_TRIG_F1]
                              : ctrl_reg[`VWI_CTRL_TRIG_F2];
    wire        ccSend   = autoMode ? !inGap : manArm;
    wire        goLine   = lineStart && lineHit && !txBusyW &&
                           ctrl_reg[`VWI_CTRL_ENABLE] && (!useCc || ccSend);
    reg  [31:0] lineData;
    always @*
    begin
        if (!useCc)
            lineData = {data3_reg, data2_reg, data1_reg, data0_reg};
        else if (!autoMode)
            lineData = {16'h0, data1_reg, data0_reg};
        else if (f1)
            lineData = {16'h0, ccChar(7'h0), ccChar(7'h0)};
        else
            lineData = {16'h0, autoPair};
    end

    // Serialiser shared by every standard
    vwi_line_tx u_tx
    (
        .clk       (clk_sys),
        .rstSync_b (rstSync_reg),
        .start     (goLine),
        .data      (lineData),
        .nBits     (lineBits),
        .biphase   (lineBip),
        .bitCycles (useCc ? CC_BIT_CYCLES[9:0] : WSS_BIT_CYCLES[9:0]),
        .txBit     (txBitW),
        .txBusy    (txBusyW),
        .txDone    (txDoneW)
    );

    // Manual trigger clears on completion; a host set in that cycle wins
    wire       wrCtrl = regWrEn && regAddr == `VWI_CTRL_ADDR;
    wire       doneManual = txDoneW && manBusy_reg;
    wire [1:0] trigSet = wrCtrl ? regWrData[3:2] : 2'h0;
    wire [1:0] trigClr = doneManual ? (manField_reg ? 2'h2 : 2'h1) : 2'h0;

    // Register file, auto-mode field counter and refresh gap
    always @(posedge clk_sys or negedge rstSync_reg)
    begin
        if (!rstSync_reg)
        begin
            data0_reg    <= 8'h00;
            data1_reg    <= 8'h00;
            data2_reg    <= 8'h00;
            data3_reg    <= 8'h00;
            ctrl_reg     <= 4'h0;
            fieldCnt_reg <= 4'h0;
            gapCnt_reg   <= 7'h00;
            manField_reg <= 1'b0;
            manBusy_reg  <= 1'b0;
            modSel_reg   <= 1'b0;
        end
        else
        begin
            // Host data writes; software keeps them inside vsync
            if (regWrEn && regAddr == `VWI_DATA0_ADDR)
                data0_reg <= regWrData;
            if (regWrEn && regAddr == `VWI_DATA1_ADDR)
                data1_reg <= regWrData;
            if (regWrEn && regAddr == `VWI_DATA2_ADDR)
                data2_reg <= regWrData;
            if (regWrEn && regAddr == `VWI_DATA3_ADDR)
                data3_reg <= regWrData;
            if (wrCtrl)
                ctrl_reg[1:0] <= regWrData[1:0];
            ctrl_reg[3:2] <= (ctrl_reg[3:2] & ~trigClr) | trigSet;
            if (goLine)
            begin
                manBusy_reg  <= useCc && !autoMode;
                manField_reg <= fieldTwo;
                modSel_reg   <= lineMod;
            end
            else if (txDoneW)
                manBusy_reg <= 1'b0;
            // Caption line counts fields; after 16, idle refresh x 16 fields
            if (lineStart && lineHit && useCc && autoMode)
            begin
                if (inGap)
                    gapCnt_reg <= gapCnt_reg - 7'h01;
                else
                begin
                    fieldCnt_reg <= fieldCnt_reg + 4'h1;
                    if (fieldCnt_reg == `VWI_CC_FIELDS)
                        gapCnt_reg <= {data3_reg[`VWI_REFRESH_MSB:
                                       `VWI_REFRESH_LSB], 4'h0};
                end
            end
            else if (!autoMode)
            begin
                fieldCnt_reg <= 4'h0;
                gapCnt_reg   <= 7'h00;
            end
        end
    end

    // Read path and registered encoder outputs
    always @(posedge clk_sys or negedge rstSync_reg)
    begin
        if (!rstSync_reg)
        begin
            regRdData     <= 8'h00;
            vbiActive     <= 1'b0;
            vbiBit        <= 1'b0;
            vbiSubcarrier <= 1'b0;
        end
        else
        begin
            vbiActive     <= txBusyW;
            vbiBit        <= txBitW;
            vbiSubcarrier <= txBusyW && modSel_reg;
            if (regRdEn)
            begin
                case (regAddr)
                    `VWI_DATA0_ADDR: regRdData <= data0_reg;
                    `VWI_DATA1_ADDR: regRdData <= data1_reg;
                    `VWI_DATA2_ADDR: regRdData <= data2_reg;
                    `VWI_DATA3_ADDR: regRdData <= data3_reg;
                    `VWI_CTRL_ADDR:  regRdData <= {3'h0, vsync, ctrl_reg};
                    default:         regRdData <= 8'h00;
                endcase
            end
        end
    end

endmodule // vwi_inserter

// *** verilog/vwi_regs.vh ***
// Register offsets, field positions and timing counts for the VBI inserter.
// Assumes byte-wide registers reached by index, two index steps apart.
`ifndef VWI_REGS_VH
`define VWI_REGS_VH

// Register indices
`define VWI_DATA0_ADDR      8'h42
`define VWI_DATA1_ADDR      8'h44
`define VWI_DATA2_ADDR      8'h46
`define VWI_DATA3_ADDR      8'h48
`define VWI_CTRL_ADDR       8'h4A

// Control and status fields
`define VWI_CTRL_ENABLE     0
`define VWI_CTRL_AUTO       1
`define VWI_CTRL_TRIG_F1    2
`define VWI_CTRL_TRIG_F2    3
`define VWI_CTRL_VSYNC      4
`define VWI_REFRESH_MSB     2
`define VWI_REFRESH_LSB     0

// Output standards and blanking-data standards
`define VWI_TV_NTSC         2'h0
`define VWI_TV_PALM         2'h1
`define VWI_TV_PAL625       2'h2
`define VWI_STD_ETSI        2'h0
`define VWI_STD_ITU         2'h1
`define VWI_STD_IEC         2'h2
`define VWI_STD_CC          2'h3

// Line positions
`define VWI_LINE_WSS625     10'h017
`define VWI_LINE_ITU525_F1  10'h016
`define VWI_LINE_ITU525_F2  10'h11D
`define VWI_LINE_IEC_F1     10'h014
`define VWI_LINE_IEC_F2     10'h11B
`define VWI_LINE_CC525_F1   10'h015
`define VWI_LINE_CC525_F2   10'h11C
`define VWI_LINE_CC625_F1   10'h016
`define VWI_LINE_CC625_F2   10'h14F

// Bit counts
`define VWI_BITS_WSS625     6'h0E
`define VWI_BITS_ITU525     6'h18
`define VWI_BITS_IEC        6'h14
`define VWI_BITS_CC         6'h10

// Caption packet constants (7-bit character values) and the 4-bit last field count of a run
`define VWI_CC_START        7'h01
`define VWI_CC_ASPECT       7'h09
`define VWI_CC_CGMS         7'h08
`define VWI_CC_END          7'h0F
`define VWI_CC_FIELDS       4'hF

// Bit cell lengths in clk_sys cycles (250 MHz)
`define VWI_CC_BIT_CYCLES   10'h1F1
`define VWI_WSS_BIT_CYCLES  10'h032

`endif

// *** verilog/vwi_line_tx.v ***
// Serialises one line of blanking data, lsb first, NRZ or bi-phase.
// Assumes start is a one-cycle pulse given only while the module is idle.
`include "vwi_regs.vh"

module vwi_line_tx
(
    // Clock and reset
    input  wire        clk,
    input  wire        rstSync_b,
    // Request
    input  wire        start,
    input  wire [31:0] data,
    input  wire [5:0]  nBits,
    input  wire        biphase,
    input  wire [9:0]  bitCycles,
    // Line output
    output reg         txBit,
    output reg         txBusy,
    output reg         txDone
);

    reg [31:0] shift_reg;
    reg [5:0]  left_reg;
    reg [9:0]  cyc_reg;
    reg        half_reg;
    reg        bip_reg;
    reg [9:0]  cells_reg;

    wire [9:0] halfLen = {1'b0, cells_reg[9:1]};
    wire       cellEnd = bip_reg ? (cyc_reg == halfLen - 10'h001)
                                 : (cyc_reg == cells_reg - 10'h001);

    // Bi-phase sends a one as high-low and a zero as low-high
    always @(posedge clk or negedge rstSync_b)
    begin
        if (!rstSync_b)
        begin
            shift_reg <= 32'h0;
            left_reg  <= 6'h0;
            cyc_reg   <= 10'h0;
            half_reg  <= 1'b0;
            bip_reg   <= 1'b0;
            cells_reg <= 10'h1;
            txBit     <= 1'b0;
            txBusy    <= 1'b0;
            txDone    <= 1'b0;
        end
        else
        begin
            txDone <= 1'b0;
            if (start && !txBusy)
            begin
                shift_reg <= data;
                left_reg  <= nBits;
                cyc_reg   <= 10'h0;
                half_reg  <= 1'b0;
                bip_reg   <= biphase;
                cells_reg <= bitCycles;
                txBusy    <= 1'b1;
                txBit     <= data[0];
            end
            else if (txBusy)
            begin
                if (!cellEnd)
                    cyc_reg <= cyc_reg + 10'h001;
                else if (bip_reg && !half_reg)
                begin
                    cyc_reg  <= 10'h0;
                    half_reg <= 1'b1;
                    txBit    <= ~shift_reg[0];
                end
                else if (left_reg == 6'h01)
                begin
                    txBusy <= 1'b0;
                    txDone <= 1'b1;
                    txBit  <= 1'b0;
                end
                else
                begin
                    cyc_reg   <= 10'h0;
                    half_reg  <= 1'b0;
                    left_reg  <= left_reg - 6'h01;
                    shift_reg <= {1'b0, shift_reg[31:1]};
                    txBit     <= shift_reg[1];
                end
            end
        end
    end

endmodule // vwi_line_tx

// *** dv/vwi_inserter_assertions.sv ***
// Port-level property checker for the VBI inserter.
// Assumes standard selects stay steady while a line is being sent.
module vwi_inserter_assertions
#(
    parameter CC_BIT_CYCLES  = 4,
    parameter WSS_BIT_CYCLES = 4
)
(
    input wire       clk_sys,
    input wire       rst_b,
    input wire [7:0] regAddr,
    input wire       regWrEn,
    input wire [7:0] regWrData,
    input wire       regRdEn,
    input wire [7:0] regRdData,
    input wire       lineStart,
    input wire [9:0] lineNum,
    input wire       fieldTwo,
    input wire       vsync,
    input wire [1:0] tvStandard,
    input wire [1:0] vbiStandard,
    input wire       vbiActive,
    input wire       vbiBit,
    input wire       vbiSubcarrier
);
    timeunit 1ns;
    timeprecision 1ps;
    int         actLen_reg;
    logic [7:0] shadow0_reg;

    // Length of the current burst and last byte written at 42h
    always @(posedge clk_sys or negedge rst_b)
        if (!rst_b)
        begin
            actLen_reg  <= 0;
            shadow0_reg <= 8'h00;
        end
        else
        begin
            actLen_reg <= vbiActive ? actLen_reg + 1 : 0;
            if (regWrEn && regAddr == 8'h42)
                shadow0_reg <= regWrData;
        end

    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    chk_read_unmapped: assert property (regRdEn && !(regAddr inside
        {8'h42, 8'h44, 8'h46, 8'h48, 8'h4A}) |=> regRdData == 8'h00)
        else $error("unmapped read not zero");
    chk_status_read: assert property (regRdEn && regAddr == 8'h4A
        |=> regRdData[7:4] == {3'b000, $past(vsync)})
        else $error("status bits wrong");
    chk_data_read: assert property (regRdEn && !regWrEn
        && regAddr == 8'h42 |=> regRdData == shadow0_reg)
        else $error("data byte 0 readback wrong");
    chk_line_delay: assert property ($rose(vbiActive)
        |-> $past(lineStart, 2))
        else $error("burst not two edges after line start");
    chk_etsi_line: assert property ($rose(vbiActive)
        && vbiStandard == 2'h0
        |-> $past(lineNum, 2) == 10'd23 && tvStandard == 2'h2)
        else $error("ETSI burst on wrong line or system");
    chk_iec_ntsc: assert property (lineStart && vbiStandard == 2'h2
        && tvStandard != 2'h0 |-> ##2 !$rose(vbiActive))
        else $error("IEC burst outside NTSC");
    chk_palm_nocc: assert property (lineStart && vbiStandard == 2'h3
        && tvStandard == 2'h1 |-> ##2 !$rose(vbiActive))
        else $error("caption burst in PAL-M");
    chk_cc_len: assert property ($fell(vbiActive)
        && vbiStandard == 2'h3
        |-> actLen_reg == 16 * CC_BIT_CYCLES)
        else $error("caption burst length wrong");
    chk_iec_len: assert property ($fell(vbiActive)
        && vbiStandard == 2'h2
        |-> actLen_reg == 20 * WSS_BIT_CYCLES)
        else $error("IEC burst length wrong");
    chk_sub_itu: assert property ($rose(vbiSubcarrier)
        |-> vbiStandard == 2'h1 && tvStandard != 2'h2)
        else $error("subcarrier outside ITU 525-line");
    chk_sub_present: assert property ($rose(vbiActive)
        && vbiStandard == 2'h1 && tvStandard != 2'h2 |-> vbiSubcarrier)
        else $error("subcarrier missing on ITU 525-line burst");
endmodule // vwi_inserter_assertions

bind vwi_inserter vwi_inserter_assertions
#(
    .CC_BIT_CYCLES (CC_BIT_CYCLES),
    .WSS_BIT_CYCLES(WSS_BIT_CYCLES)
) chk (.clk_sys(clk_sys), .rst_b(rst_b), .regAddr(regAddr),
    .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn),
    .regRdData(regRdData), .lineStart(lineStart), .lineNum(lineNum),
    .fieldTwo(fieldTwo), .vsync(vsync), .tvStandard(tvStandard),
    .vbiStandard(vbiStandard), .vbiActive(vbiActive), .vbiBit(vbiBit),
    .vbiSubcarrier(vbiSubcarrier));

// *** dv/vwi_tv_receiver.sv ***
// Receiver model: decodes one blanking-data burst per line.
// Assumes bit cells of BITC cycles starting when the burst goes active.
module vwi_tv_receiver
#(
    parameter BITC = 4
)
(
    input  wire         clk,
    input  wire         rst_b,
    input  wire         vbiActive,
    input  wire         vbiBit,
    output logic [31:0] rxWord,
    output logic [31:0] rxHalf,
    output logic [5:0]  rxCount,
    output int          rxLines
);
    timeunit 1ns;
    timeprecision 1ps;
    int cyc;

    // Sample early in each cell: bi-phase first half equals the bit value
    always @(posedge clk or negedge rst_b)
        if (!rst_b)
        begin
            cyc     <= 0;
            rxLines <= 0;
            rxWord  <= 32'h0;
            rxHalf  <= 32'h0;
            rxCount <= 6'h0;
        end
        else if (!vbiActive)
        begin
            if (cyc != 0)
                rxLines <= rxLines + 1;
            cyc <= 0;
        end
        else
        begin
            if (cyc == 0)
            begin
                rxWord  <= 32'h0;
                rxHalf  <= 32'h0;
                rxCount <= 6'h0;
            end
            if (cyc % BITC == 1)
            begin
                rxWord[rxCount] <= vbiBit;
                rxCount         <= rxCount + 6'h1;
            end
            // Late in the cell: inverse of the bit for bi-phase
            if (cyc % BITC == BITC / 2 + 1)
                rxHalf[rxCount - 6'h1] <= vbiBit;
            cyc <= cyc + 1;
        end
endmodule // vwi_tv_receiver

// *** dv/vwi_inserter_bench.sv ***
// Self-checking bench for the VBI inserter with short bit cells.
// Assumes the bench plays TV timing generator and host software.
`include "vwi_regs.vh"
module vwi_inserter_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int BITC = 4;
    logic        clk_sys = 1'b0;
    logic        rst_b = 1'b0;
    logic [7:0]  regAddr = 8'h00;
    logic        regWrEn = 1'b0;
    logic [7:0]  regWrData = 8'h00;
    logic        regRdEn = 1'b0;
    logic [7:0]  regRdData;
    logic        lineStart = 1'b0;
    logic [9:0]  lineNum = 10'h000;
    logic        fieldTwo = 1'b0;
    logic        vsync = 1'b0;
    logic [1:0]  tvStandard = 2'h0;
    logic [1:0]  vbiStandard = 2'h0;
    logic        vbiActive;
    logic        vbiBit;
    logic [31:0] rxWord;
    logic [31:0] rxHalf;
    logic [15:0] pq [$];
    logic [5:0]  rxCount;
    int          rxLines;
    int          n_errors = 0;
    int          n_checks = 0;
    logic [31:0] rnd = 32'h000022CC;
    logic [7:0]  dat [4];
    logic [7:0]  addrs [5] = '{8'h42, 8'h44, 8'h46, 8'h48, 8'h4A};
    // Rows: data standard, TV system, line, field two, bits (0 = none)
    int tab [9][5] = '{'{0, 2, 23, 0, 14}, '{0, 0, 23, 0, 0},
        '{0, 2, 22, 0, 0}, '{1, 0, 22, 0, 24}, '{1, 1, 285, 1, 24},
        '{1, 2, 23, 0, 14}, '{2, 0, 20, 0, 20}, '{2, 0, 283, 1, 20},
        '{2, 1, 20, 0, 0}};

    vwi_inserter #(.CC_BIT_CYCLES(BITC), .WSS_BIT_CYCLES(BITC)) uut (
        .clk_sys(clk_sys), .rst_b(rst_b), .regAddr(regAddr),
        .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn),
        .regRdData(regRdData), .lineStart(lineStart), .lineNum(lineNum),
        .fieldTwo(fieldTwo), .vsync(vsync), .tvStandard(tvStandard),
        .vbiStandard(vbiStandard), .vbiActive(vbiActive), .vbiBit(vbiBit),
        .vbiSubcarrier());
    vwi_tv_receiver #(.BITC(BITC)) rx (.clk(clk_sys), .rst_b(rst_b),
        .vbiActive(vbiActive), .vbiBit(vbiBit), .rxWord(rxWord),
        .rxHalf(rxHalf),
        .rxCount(rxCount), .rxLines(rxLines));

    // 250 MHz clock
    always #2 clk_sys = ~clk_sys;

    function automatic logic [31:0] xs();
        rnd ^= rnd << 13;
        rnd ^= rnd >> 17;
        rnd ^= rnd << 5;
        return rnd;
    endfunction

    // Caption character with odd parity in bit 7
    function automatic logic [7:0] odd(input logic [6:0] c);
        return {~^c, c};
    endfunction

    // Field-2 pairs of one automatic run, first character in the low byte
    task automatic build_packets();
        int c [16];
        int s;
        int i;
        c = '{1, 9, 64 + dat[0][5:0], 64 + {dat[1][3:0], dat[0][7:6]},
            64 + dat[1][4], 0, 15, 0, 1, 8,
            64 + {dat[2][1:0], dat[1][7:5]}, dat[2][7:2], 15, 0, 0, 0};
        s = 0;
        for (i = 0; i < 7; i++)
            s += c[i];
        c[7] = (128 - s % 128) % 128;
        s = 0;
        for (i = 8; i < 13; i++)
            s += c[i];
        c[13] = (128 - s % 128) % 128;
        c[14] = c[12];
        c[15] = c[13];
        pq = {};
        for (i = 0; i < 16; i += 2)
            pq.push_back({odd(7'(c[i + 1])), odd(7'(c[i]))});
    endtask

    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        n_checks++;
        if (g !== e)
        begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        regAddr = a;
        regWrData = d;
        regWrEn = 1'b1;
        @(negedge clk_sys);
        regWrEn = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge clk_sys);
        regAddr = a;
        regRdEn = 1'b1;
        @(negedge clk_sys);
        regRdEn = 1'b0;
        chk("register read", {24'h0, e}, {24'h0, regRdData});
    endtask

    // One TV line; all-ones word means only the line and bit counts are compared
    task automatic run_line(int n, bit f2, int nb, logic [31:0] w);
        int l0;
        int i;
        logic [31:0] h;
        l0 = rxLines;
        i = 0;
        @(negedge clk_sys);
        lineNum = n[9:0];
        fieldTwo = f2;
        lineStart = 1'b1;
        @(negedge clk_sys);
        lineStart = 1'b0;
        while (!vbiActive && i < 4)
        begin
            @(negedge clk_sys);
            i++;
        end
        while (vbiActive && i < 300)
        begin
            @(negedge clk_sys);
            i++;
        end
        repeat (2) @(negedge clk_sys);
        chk("line count", 32'(nb != 0), 32'(rxLines - l0));
        if (nb != 0)
        begin
            chk("bit count", 32'(nb), {26'h0, rxCount});
            if (w !== '1)
            begin
                h = nb == 14 ? ~w & 32'((64'd1 << nb) - 64'd1) : w;
                chk("word", w, rxWord);
                chk("second half", h, rxHalf);
            end
        end
    endtask

    task results();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Watchdog well beyond the expected run of some 2100 cycles
    initial
    begin
        #(60000 * 4);
        n_errors++;
        results();
    end

    initial
    begin
        repeat (4) @(negedge clk_sys);
        rst_b = 1'b1;
        repeat (3) @(negedge clk_sys);
        foreach (addrs[k]) rd(addrs[k], 8'h00);
        wr(8'h43, 8'hFF);
        rd(8'h43, 8'h00);
        vsync = 1'b1;
        wr(8'h4A, 8'hE0);
        rd(8'h4A, 8'h10);
        // Payload written while vsync is high, as manual mode demands
        foreach (dat[k])
        begin
            dat[k] = 8'(xs());
            wr(addrs[k], dat[k]);
        end
        foreach (dat[k]) rd(addrs[k], dat[k]);
        vsync = 1'b0;
        wr(8'h4A, 8'h01);
        $display("test registers done");
        foreach (tab[r])
        begin
            vbiStandard = 2'(tab[r][0]);
            tvStandard = 2'(tab[r][1]);
            run_line(tab[r][2], tab[r][3][0], tab[r][4],
                {dat[3], dat[2], dat[1], dat[0]} &
                32'((64'd1 << tab[r][4]) - 64'd1));
        end
        $display("test wide-screen done");
        vbiStandard = `VWI_STD_CC;
        tvStandard = `VWI_TV_NTSC;
        run_line(21, 0, 0, 0);
        wr(8'h4A, 8'h05);
        run_line(21, 0, 16, {dat[1], dat[0]});
        rd(8'h4A, 8'h01);
        tvStandard = `VWI_TV_PAL625;
        wr(8'h4A, 8'h09);
        run_line(335, 1, 16, {dat[1], dat[0]});
        rd(8'h4A, 8'h01);
        $display("test manual done");
        tvStandard = `VWI_TV_NTSC;
        // Nonzero refresh so the idle gap after a run is exercised
        vsync = 1'b1;
        dat[3][2:0] = 3'(xs()) | 3'h1;
        wr(8'h48, dat[3]);
        vsync = 1'b0;
        build_packets();
        wr(8'h4A, 8'h03);
        foreach (pq[k])
        begin
            run_line(21, 0, 16, 32'h8080);
            run_line(284, 1, 16, {16'h0, pq[k]});
            chk("parity", 2'b11, {^rxWord[15:8], ^rxWord[7:0]});
        end
        // Refresh gap: this many caption lines stay empty
        repeat (16 * dat[3][2:0])
            run_line(21, 0, 0, 0);
        run_line(21, 0, 16, 32'h8080);
        run_line(284, 1, 16, {16'h0, pq[0]});
        tvStandard = `VWI_TV_PALM;
        run_line(21, 0, 0, 0);
        run_line(284, 1, 0, 0);
        $display("test auto done");
        results();
    end
endmodule // vwi_inserter_bench
